/* logic/mbus_arb_pkg.sv */
// memory bus arbiter constants, address map, wait figures and decode helpers
// Summary of operation
// R1 - external zones wait from timing inputs, ready-stretched
// R2 - external waveforms always carry one wait minimum
// R3 - posted external write only with buffer space
// R4 - cpu/dma same-target clash costs one cycle
// R5 - otp wait programmable, never below one
// R6 - flash paged/random waits, min one, random>=paged
// R7 - flash password reads fixed sixteen waits
// R8 - boot rom always exactly one wait
// R9 - dma word costs four base cycles
// R10 - program read bus: 22-bit address, 32-bit data
// R11 - data buses: 32-bit address and data
// R12 - fetch, read, write run together
// R13 - fixed priority: dwrite, pwrite, dread, pread, fetch
// R14 - never data and program write together
// R15 - never program read and fetch together
// R16 - bridge drives 16-bit address, 16/32 data
// R17 - second frame takes 16-bit accesses only
// R18 - first frame: 16/32-bit, cpu only
// R19 - third frame: 16/32-bit, dma allowed
// R20 - protected frames keep write-then-read order
// R21 - counter loads at start, acks after expiry
package mbus_arb_pkg;

    localparam int NRQ    = 6;
    localparam int NTG    = 6;
    localparam int CNT_W  = 6;
    localparam int PAGE_LSB = 3;
    localparam int PAGE_W = 22 - PAGE_LSB;

    // requester index doubles as priority, lowest index wins
    localparam int RQ_DW  = 0;
    localparam int RQ_PW  = 1;
    localparam int RQ_DR  = 2;
    localparam int RQ_PR  = 3;
    localparam int RQ_FE  = 4;
    localparam int RQ_DMA = 5;

    localparam int TG_SARAM  = 0;
    localparam int TG_PERIPH = 1;
    localparam int TG_FLASH  = 2;
    localparam int TG_OTP    = 3;
    localparam int TG_BOOT   = 4;
    localparam int TG_EXT    = 5;

    localparam logic [31:0] PERIPH_LO = 32'h0000_0800;
    localparam logic [31:0] PERIPH_HI = 32'h0000_7FFF;
    localparam logic [31:0] EXT_LO    = 32'h0001_0000;
    localparam logic [31:0] ZONE6_LO  = 32'h0010_0000;
    localparam logic [31:0] ZONE7_LO  = 32'h0020_0000;
    localparam logic [31:0] FLASH_LO  = 32'h0030_0000;
    localparam logic [31:0] FLASH_HI  = 32'h0033_FFFF;
    localparam logic [31:0] PASSWD_LO = 32'h0033_FFF8;
    localparam logic [31:0] OTP_LO    = 32'h0038_0400;
    localparam logic [31:0] OTP_HI    = 32'h0038_07FF;
    localparam logic [31:0] BOOT_LO   = 32'h003F_E000;
    localparam logic [31:0] BOOT_HI   = 32'h003F_FFFF;
    localparam logic [15:0] PF1_LO    = 16'h6000;
    localparam logic [15:0] PF2_LO    = 16'h7000;
    localparam logic [15:0] PF3_LO    = 16'h5000;
    localparam logic [15:0] PF3_HI    = 16'h5FFF;

    localparam logic [1:0] FR_0 = 2'h0;
    localparam logic [1:0] FR_1 = 2'h1;
    localparam logic [1:0] FR_2 = 2'h2;
    localparam logic [1:0] FR_3 = 2'h3;

    localparam int DMA_BASE_CYCLES = 4;
    localparam logic [CNT_W-1:0] W_ZERO      = 6'h00;
    localparam logic [CNT_W-1:0] W_ONE       = 6'h01;
    localparam logic [CNT_W-1:0] W_PASSWD    = 6'h10;
    localparam logic [CNT_W-1:0] W_PF_RD     = 6'h02;
    localparam logic [CNT_W-1:0] W_PF_DMA_RD = 6'h01;
    localparam logic [CNT_W-1:0] W_DMA_EXTRA = CNT_W'(DMA_BASE_CYCLES - 1);

    function automatic logic [2:0] target_of(input logic [31:0] a);
        if (a < PERIPH_LO) return 3'(TG_SARAM);
        if (a <= PERIPH_HI) return 3'(TG_PERIPH);
        if (a < EXT_LO) return 3'(TG_SARAM);
        if (a < FLASH_LO) return 3'(TG_EXT);
        if (a <= FLASH_HI) return 3'(TG_FLASH);
        if (a >= OTP_LO && a <= OTP_HI) return 3'(TG_OTP);
        if (a >= BOOT_LO && a <= BOOT_HI) return 3'(TG_BOOT);
        return 3'(TG_SARAM);
    endfunction

    function automatic logic [1:0] frame_of(input logic [15:0] a);
        if (a >= PF2_LO) return FR_2;
        if (a >= PF1_LO) return FR_1;
        if (a >= PF3_LO && a <= PF3_HI) return FR_3;
        return FR_0;
    endfunction

    function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] w);
        return (w == W_ZERO) ? W_ONE : w;
    endfunction

endpackage

/* logic/wait_ctl_if.sv */
// handshake between the arbiter and one region wait counter
`timescale 1ns/1ps
`default_nettype none
interface wait_ctl_if;
    logic                           start;
    logic [mbus_arb_pkg::CNT_W-1:0] count;
    logic                           stretch_en;
    logic                           ready;
    logic                           busy;
    logic                           done;
    modport arbiter (output start, output count, output stretch_en, output ready,
                     input busy, input done);
    modport counter (input start, input count, input stretch_en, input ready,
                     output busy, output done);
endinterface
`default_nettype wire

/* logic/wait_counter.sv */
// per-region wait-state counter with optional ready stretch
`timescale 1ns/1ps
`default_nettype none
module wait_counter (
    input  wire logic   clk,
    input  wire logic   rst,
    wait_ctl_if.counter wc
);
    typedef enum logic [1:0] {WC_IDLE = 2'b01, WC_COUNT = 2'b10} wc_state_t;
    typedef struct packed {
        wc_state_t                      st;
        logic [mbus_arb_pkg::CNT_W-1:0] cnt;
        logic                           stretch;
    } wc_reg_t;

    wc_reg_t cur_ff;
    wc_reg_t nxt;
    logic    expired;

    assign expired = (cur_ff.st == WC_COUNT) && (cur_ff.cnt == mbus_arb_pkg::W_ZERO);
    // stretch latched at start so a late enable change cannot cut a cycle short
    assign wc.done = expired && (!cur_ff.stretch || wc.ready); // [R21] [R1]
    assign wc.busy = (cur_ff.st == WC_COUNT);

    always_comb begin
        nxt = cur_ff;
        case (cur_ff.st)
            WC_IDLE: begin
                if (wc.start) begin
                    nxt.st      = WC_COUNT; // [R21]
                    nxt.cnt     = wc.count;
                    nxt.stretch = wc.stretch_en;
                end
            end
            WC_COUNT: begin
                if (wc.done) begin
                    nxt.st = WC_IDLE;
                    if (wc.start) begin
                        nxt.st      = WC_COUNT;
                        nxt.cnt     = wc.count;
                        nxt.stretch = wc.stretch_en;
                    end
                end else if (!expired) begin
                    nxt.cnt = cur_ff.cnt - mbus_arb_pkg::W_ONE;
                end
            end
            default: begin
                nxt.st = WC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '{st: WC_IDLE, cnt: '0, stretch: 1'b0};
        end else begin
            cur_ff <= nxt;
        end
    end
endmodule
`default_nettype wire

/* logic/memory_bus_arbiter.sv */
// memory bus arbiter: per-target priority grant, wait states, peripheral bridge
`timescale 1ns/1ps
`default_nettype none
module memory_bus_arbiter (
    input  wire logic        clk,
    input  wire logic        rst,
    // cpu requests: [0] dwrite [1] pwrite [2] dread [3] pread [4] fetch
    input  wire logic [4:0]  cpu_req,
    input  wire logic [21:0] prog_addr,
    input  wire logic [31:0] rd_addr,
    input  wire logic [31:0] wr_addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        cpu_size32,
    output logic [4:0]       cpu_ack,
    output logic [4:0]       cpu_err,
    output logic [31:0]      prog_rdata,
    output logic [31:0]      data_rdata,
    input  wire logic        dma_req,
    input  wire logic        dma_we,
    input  wire logic [31:0] dma_addr,
    input  wire logic [31:0] dma_wdata,
    input  wire logic        dma_size32,
    output logic             dma_ack,
    output logic             dma_err,
    output logic [31:0]      dma_rdata,
    // one lane per target, index as in the package
    output logic [5:0]       tgt_strobe,
    output logic [5:0]       tgt_we,
    output logic [5:0][31:0] tgt_addr,
    output logic [5:0][31:0] tgt_wdata,
    input  wire logic [5:0][31:0] tgt_rdata,
    output logic [15:0]      periph_addr,
    output logic [31:0]      periph_wdata,
    output logic             periph_size32,
    // wait configuration, held static by the owner of the settings
    input  wire logic [2:0][4:0] external_zone_timing_regs,
    input  wire logic [2:0]  zone_ready_en,
    input  wire logic        external_ready_input,
    input  wire logic        wbuf_en,
    input  wire logic        wbuf_space,
    input  wire logic [3:0]  flash_page_wait,
    input  wire logic [3:0]  flash_rand_wait,
    input  wire logic [3:0]  otp_wait
);
    localparam int NRQ = mbus_arb_pkg::NRQ;
    localparam int NTG = mbus_arb_pkg::NTG;
    localparam int CW  = mbus_arb_pkg::CNT_W;

    typedef struct packed {
        logic                                  xrdy_meta;
        logic                                  xrdy_sync;
        logic [NRQ-1:0]                        served;
        logic [NRQ-1:0]                        ack;
        logic [NRQ-1:0]                        err;
        logic [NTG-1:0][2:0]                   owner;
        logic [NTG-1:0]                        posted;
        logic [NTG-1:0]                        strobe;
        logic [NTG-1:0]                        we;
        logic [NTG-1:0][31:0]                  addr;
        logic [NTG-1:0][31:0]                  wdata;
        logic [31:0]                           prog_rdata;
        logic [31:0]                           data_rdata;
        logic [31:0]                           dma_rdata;
        logic [15:0]                           periph_addr;
        logic [31:0]                           periph_wdata;
        logic                                  periph_size32;
        logic                                  periph_turn;
        logic                                  page_valid;
        logic [mbus_arb_pkg::PAGE_W-1:0]       flash_page;
    } arb_state_t;

    arb_state_t st_ff;
    arb_state_t nxt;

    logic [NRQ-1:0]        req_all;
    logic [NRQ-1:0]        pend;
    logic [NRQ-1:0][31:0]  rq_addr;
    logic [NRQ-1:0][2:0]   rq_tgt;
    logic [NRQ-1:0]        rq_we;
    logic [NRQ-1:0]        rq_size32;
    logic [NRQ-1:0][31:0]  rq_wdata;
    logic [NTG-1:0]        wc_start;
    logic [NTG-1:0][CW-1:0] wc_count;
    logic [NTG-1:0]        wc_stretch;
    logic [NTG-1:0]        wc_busy;
    logic [NTG-1:0]        wc_done;

    // requester view: fetch and program read share the program read bus
    always_comb begin
        req_all = {dma_req, cpu_req};
        for (int r = 0; r < NRQ; r++) begin
            rq_we[r]     = 1'b0;
            rq_size32[r] = cpu_size32;
            rq_wdata[r]  = wr_data;
            rq_addr[r]   = rd_addr;
        end
        rq_addr[mbus_arb_pkg::RQ_DW] = wr_addr; // [R11]
        rq_addr[mbus_arb_pkg::RQ_PW] = wr_addr;
        rq_addr[mbus_arb_pkg::RQ_PR] = {10'h000, prog_addr}; // [R10]
        rq_addr[mbus_arb_pkg::RQ_FE] = {10'h000, prog_addr};
        rq_addr[mbus_arb_pkg::RQ_DMA] = dma_addr;
        rq_we[mbus_arb_pkg::RQ_DW] = 1'b1;
        rq_we[mbus_arb_pkg::RQ_PW] = 1'b1;
        rq_we[mbus_arb_pkg::RQ_DMA] = dma_we;
        rq_size32[mbus_arb_pkg::RQ_DMA] = dma_size32;
        rq_wdata[mbus_arb_pkg::RQ_DMA] = dma_wdata;
        for (int r = 0; r < NRQ; r++) begin
            rq_tgt[r] = mbus_arb_pkg::target_of(rq_addr[r]);
            // a request is new until served; ack/err block the held request
            pend[r] = req_all[r] && !st_ff.served[r] && !st_ff.ack[r] && !st_ff.err[r];
        end
        pend[mbus_arb_pkg::RQ_PW] = pend[mbus_arb_pkg::RQ_PW]
                                  && !req_all[mbus_arb_pkg::RQ_DW]; // [R14]
        pend[mbus_arb_pkg::RQ_FE] = pend[mbus_arb_pkg::RQ_FE]
                                  && !req_all[mbus_arb_pkg::RQ_PR]; // [R15]
    end

    always_comb begin
        logic [NRQ-1:0]  cand;
        logic [CW-1:0]   w;
        logic [CW-1:0]   page_eff;
        logic [CW-1:0]   rand_eff;
        logic [1:0]      zone;
        logic [1:0]      frame;
        logic            turn;
        logic            found;
        logic            clash;
        logic            is_dma;
        logic            legal;
        int              r;
        int              o;
        cand     = '0;
        w        = mbus_arb_pkg::W_ZERO;
        zone     = 2'h0;
        frame    = mbus_arb_pkg::FR_0;
        turn     = 1'b0;
        found    = 1'b0;
        clash    = 1'b0;
        is_dma   = 1'b0;
        legal    = 1'b1;
        r        = 0;
        o        = 0;
        nxt      = st_ff;
        nxt.xrdy_meta   = external_ready_input;
        nxt.xrdy_sync   = st_ff.xrdy_meta;
        nxt.ack         = '0;
        nxt.err         = '0;
        nxt.strobe      = '0;
        nxt.periph_turn = 1'b0;
        wc_start   = '0;
        wc_count   = '0;
        wc_stretch = '0;
        page_eff = mbus_arb_pkg::at_least_one(CW'(flash_page_wait)); // [R6]
        rand_eff = mbus_arb_pkg::at_least_one(CW'(flash_rand_wait));
        if (rand_eff < page_eff) begin
            rand_eff = page_eff; // [R6]
        end
        // each target arbitrates on its own, so different targets overlap
        for (int t = 0; t < NTG; t++) begin // [R12]
            turn = 1'b0;
            if (wc_done[t]) begin
                o = int'(st_ff.owner[t]);
                if (!st_ff.posted[t]) begin
                    nxt.ack[o]    = 1'b1; // [R21]
                    nxt.served[o] = 1'b0;
                    if (o == mbus_arb_pkg::RQ_DMA) begin
                        nxt.dma_rdata = tgt_rdata[t];
                    end else if (o == mbus_arb_pkg::RQ_DR) begin
                        nxt.data_rdata = tgt_rdata[t];
                    end else if (o == mbus_arb_pkg::RQ_PR || o == mbus_arb_pkg::RQ_FE) begin
                        nxt.prog_rdata = tgt_rdata[t];
                    end
                end
                if (t == mbus_arb_pkg::TG_PERIPH && st_ff.we[t]) begin
                    nxt.periph_turn = 1'b1;
                    turn = 1'b1;
                end
            end
            if (t == mbus_arb_pkg::TG_PERIPH && st_ff.periph_turn) begin
                turn = 1'b1;
            end
            for (int q = 0; q < NRQ; q++) begin
                cand[q] = pend[q] && (rq_tgt[q] == 3'(t));
                // protected frames: a read is held in the write's done cycle and the cycle after it
                if (t == mbus_arb_pkg::TG_PERIPH && turn && !rq_we[q]
                    && mbus_arb_pkg::frame_of(rq_addr[q][15:0]) != mbus_arb_pkg::FR_0) begin
                    cand[q] = 1'b0; // [R20]
                end
            end
            found = 1'b0;
            r = 0;
            for (int q = NRQ - 1; q >= 0; q--) begin
                if (cand[q]) begin
                    found = 1'b1; // [R13]
                    r = q;
                end
            end
            clash = cand[mbus_arb_pkg::RQ_DMA] && (|cand[mbus_arb_pkg::RQ_FE:0]); // [R4]
            is_dma = (r == mbus_arb_pkg::RQ_DMA);
            if (found && (!wc_busy[t] || wc_done[t])) begin
                legal = 1'b1;
                w = mbus_arb_pkg::W_ZERO;
                wc_stretch[t] = 1'b0;
                nxt.posted[t] = 1'b0;
                case (t)
                    mbus_arb_pkg::TG_PERIPH: begin
                        frame = mbus_arb_pkg::frame_of(rq_addr[r][15:0]);
                        if (frame == mbus_arb_pkg::FR_2 && rq_size32[r]) begin
                            legal = 1'b0; // [R17]
                        end
                        if ((frame == mbus_arb_pkg::FR_1 || frame == mbus_arb_pkg::FR_2)
                            && is_dma) begin
                            legal = 1'b0; // [R18]
                        end
                        // frame 3 passes both widths and the dma engine
                        if (!rq_we[r]) begin
                            w = is_dma ? mbus_arb_pkg::W_PF_DMA_RD : mbus_arb_pkg::W_PF_RD; // [R19]
                        end
                    end
                    mbus_arb_pkg::TG_FLASH: begin
                        if (rq_addr[r] >= mbus_arb_pkg::PASSWD_LO) begin
                            w = mbus_arb_pkg::W_PASSWD; // [R7]
                        end else if (st_ff.page_valid && st_ff.flash_page
                                     == rq_addr[r][21:mbus_arb_pkg::PAGE_LSB]) begin
                            w = page_eff; // [R6]
                        end else begin
                            w = rand_eff; // [R6]
                        end
                        nxt.page_valid = 1'b1;
                        nxt.flash_page = rq_addr[r][21:mbus_arb_pkg::PAGE_LSB];
                    end
                    mbus_arb_pkg::TG_OTP: begin
                        w = mbus_arb_pkg::at_least_one(CW'(otp_wait)); // [R5]
                    end
                    mbus_arb_pkg::TG_BOOT: begin
                        w = mbus_arb_pkg::W_ONE; // [R8]
                    end
                    mbus_arb_pkg::TG_EXT: begin
                        if (rq_addr[r] < mbus_arb_pkg::ZONE6_LO) begin
                            zone = 2'h0;
                        end else if (rq_addr[r] < mbus_arb_pkg::ZONE7_LO) begin
                            zone = 2'h1;
                        end else begin
                            zone = 2'h2;
                        end
                        w = mbus_arb_pkg::at_least_one(
                            CW'(external_zone_timing_regs[zone])); // [R1] [R2]
                        wc_stretch[t] = zone_ready_en[zone]; // [R1]
                        nxt.posted[t] = rq_we[r] && wbuf_en && wbuf_space; // [R3]
                    end
                    default: begin
                        w = mbus_arb_pkg::W_ZERO;
                    end
                endcase
                if (is_dma) begin
                    w = w + mbus_arb_pkg::W_DMA_EXTRA; // [R9]
                end
                if (clash) begin
                    w = w + mbus_arb_pkg::W_ONE; // [R4]
                end
                if (!legal) begin
                    nxt.err[r] = 1'b1;
                    nxt.posted[t] = st_ff.posted[t];
                end else begin
                    wc_start[t]  = 1'b1; // [R21]
                    wc_count[t]  = w;
                    nxt.strobe[t] = 1'b1;
                    nxt.owner[t] = 3'(r);
                    nxt.we[t]    = rq_we[r];
                    nxt.addr[t]  = rq_addr[r];
                    nxt.wdata[t] = rq_wdata[r];
                    if (nxt.posted[t]) begin
                        nxt.ack[r] = 1'b1; // [R3]
                    end else begin
                        nxt.served[r] = 1'b1;
                    end
                    if (t == mbus_arb_pkg::TG_PERIPH) begin
                        nxt.periph_addr   = rq_addr[r][15:0]; // [R16]
                        nxt.periph_wdata  = rq_wdata[r];
                        nxt.periph_size32 = rq_size32[r];
                    end
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NTG; g++) begin : g_lane
            wait_ctl_if wc ();
            assign wc.start      = wc_start[g];
            assign wc.count      = wc_count[g];
            assign wc.stretch_en = wc_stretch[g];
            // only the external lane can be stretched; its enable gates it
            assign wc.ready      = st_ff.xrdy_sync;
            assign wc_busy[g]    = wc.busy;
            assign wc_done[g]    = wc.done;
            wait_counter u_cnt (
                .clk (clk),
                .rst (rst),
                .wc  (wc.counter)
            );
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt;
        end
    end

    assign cpu_ack       = st_ff.ack[mbus_arb_pkg::RQ_FE:0];
    assign cpu_err       = st_ff.err[mbus_arb_pkg::RQ_FE:0];
    assign dma_ack       = st_ff.ack[mbus_arb_pkg::RQ_DMA];
    assign dma_err       = st_ff.err[mbus_arb_pkg::RQ_DMA];
    assign prog_rdata    = st_ff.prog_rdata;
    assign data_rdata    = st_ff.data_rdata;
    assign dma_rdata     = st_ff.dma_rdata;
    assign tgt_strobe    = st_ff.strobe;
    assign tgt_we        = st_ff.we;
    assign tgt_addr      = st_ff.addr;
    assign tgt_wdata     = st_ff.wdata;
    assign periph_addr   = st_ff.periph_addr;
    assign periph_wdata  = st_ff.periph_wdata;
    assign periph_size32 = st_ff.periph_size32;
endmodule
`default_nettype wire

/* bench/target_model.sv */
// same-clock target memories answering on every lane
`timescale 1ns/1ps
`default_nettype none
module target_model (
    input  wire logic [5:0][31:0] tgt_addr,
    output logic      [5:0][31:0] tgt_rdata
);
    // data mirrors the held address, so a stale lane shows up as wrong data
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            tgt_rdata[i] = {tgt_addr[i][15:0], 16'h5A5A ^ 16'(i)};
        end
    end
endmodule
`default_nettype wire

/* bench/mbus_arb_sva.sv */
// port-level assertions for the memory bus arbiter
`timescale 1ns/1ps
`default_nettype none
module mbus_arb_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [4:0]  cpu_req,
    input wire logic [31:0] rd_addr,
    input wire logic [31:0] wr_addr,
    input wire logic        cpu_size32,
    input wire logic [4:0]  cpu_ack,
    input wire logic [4:0]  cpu_err,
    input wire logic        dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic        dma_ack,
    input wire logic        dma_err,
    input wire logic [5:0]  tgt_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // lone data read, so a lane strobe can only be its own
    wire logic dr_only = cpu_req == 5'h04 && !dma_req;
    sequence s_dr(int l, logic ok); dr_only && tgt_strobe[l] && ok; endsequence
    sequence s_gap8; !cpu_ack[2] [*8]; endsequence
    property p_sram; s_dr(0, rd_addr < 32'h0000_0800) |=> cpu_ack[2]; endproperty
    property p_boot; s_dr(4, 1'b1) |=> !cpu_ack[2] ##1 cpu_ack[2]; endproperty
    property p_pass;
        s_dr(2, rd_addr >= 32'h0033_FFF8 && rd_addr <= 32'h0033_FFFF)
            |=> s_gap8 ##1 s_gap8 ##1 cpu_ack[2];
    endproperty
    property p_dma;
        dma_req && cpu_req == 5'h00 && tgt_strobe[0] |=> !dma_ack [*3] ##1 dma_ack;
    endproperty
    property p_pf2;
        $rose(cpu_req[0]) && cpu_size32 && wr_addr[31:12] == 20'h0_0007
            |=> cpu_err[0] && !tgt_strobe[1];
    endproperty
    property p_pf1;
        $rose(dma_req) && cpu_req == 5'h00 && dma_addr[31:12] == 20'h0_0006 |=> dma_err;
    endproperty
    property p_dwpw; !(cpu_ack[0] && cpu_ack[1]); endproperty
    property p_prfe; !(cpu_ack[3] && cpu_ack[4]); endproperty
    a_sram: assert property (p_sram) else $error("sram read ack late");
    a_boot: assert property (p_boot) else $error("boot wait wrong");
    a_pass: assert property (p_pass) else $error("password wait wrong");
    a_dma: assert property (p_dma) else $error("dma word cost wrong");
    a_pf2: assert property (p_pf2) else $error("frame2 wide access taken");
    a_pf1: assert property (p_pf1) else $error("frame1 dma access taken");
    a_dwpw: assert property (p_dwpw) else $error("two writes at once");
    a_prfe: assert property (p_prfe) else $error("read and fetch at once");
endmodule
bind memory_bus_arbiter mbus_arb_sva i_mbus_arb_sva (.clk, .rst, .cpu_req, .rd_addr,
    .wr_addr, .cpu_size32, .cpu_ack, .cpu_err, .dma_req, .dma_addr, .dma_ack, .dma_err,
    .tgt_strobe);
`default_nettype wire

/* bench/test_memory_bus_arbiter.sv */
// self-checking bench for the memory bus arbiter
`timescale 1ns/1ps
`default_nettype none
module test_memory_bus_arbiter;
    logic             clk = 1'b0, rst = 1'b1, s32 = 1'b0, dma_req = 1'b0, dma_we = 1'b0;
    logic             wbuf_en = 1'b0, wbuf_space = 1'b0, dma_ack, dma_err, periph_size32;
    logic [4:0]       cpu_req = 5'h00, cpu_ack, cpu_err;
    logic [31:0]      ad = 32'h0000_0000, prog_rdata, data_rdata, dma_rdata, periph_wdata;
    logic [15:0]      periph_addr;
    logic [5:0]       tgt_strobe, tgt_we;
    logic [5:0][31:0] tgt_addr, tgt_wdata, tgt_rdata;
    logic [2:0][4:0]  external_zone_timing_regs = 15'h0000;
    logic [3:0]       flash_page_wait = 4'h0, flash_rand_wait = 4'h0, otp_wait = 4'h0;
    logic [2:0]       zr = 3'h0;
    logic             rdy = 1'b1;
    int               n_fail = 0, cmp_count = 0, n;
    always #50 clk = ~clk;
    // one shared address bus keeps every requester's address in step
    memory_bus_arbiter i_memory_bus_arbiter (.clk, .rst, .cpu_req, .prog_addr(ad[21:0]),
        .rd_addr(ad), .wr_addr(ad), .wr_data(ad), .cpu_size32(s32), .cpu_ack, .cpu_err,
        .prog_rdata, .data_rdata, .dma_req, .dma_we, .dma_addr(ad), .dma_wdata(ad),
        .dma_size32(s32), .dma_ack, .dma_err, .dma_rdata, .tgt_strobe, .tgt_we, .tgt_addr,
        .tgt_wdata, .tgt_rdata, .periph_addr, .periph_wdata, .periph_size32,
        .external_zone_timing_regs, .zone_ready_en(zr), .external_ready_input(rdy),
        .wbuf_en, .wbuf_space, .flash_page_wait, .flash_rand_wait, .otp_wait);
    target_model i_target_model (.tgt_addr, .tgt_rdata);
    task chk(input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // requester 5 is a dma read, 6 a dma write
    task req(input int b, input logic v);
        if (b > 4) {dma_req, dma_we} = {v, b == 6};
        else cpu_req[b] = v;
    endtask
    // edges from the taking edge to the answer, negative when refused
    task wt(input int b, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (((b > 4) ? dma_ack | dma_err : cpu_ack[b] | cpu_err[b]) !== 1'b1 && k < 40);
        if (k == 40) begin
            n_fail++;
            end_of_test();
        end
        if (((b > 4) ? dma_err : cpu_err[b]) === 1'b1) k = -k;
        @(negedge clk);
        req(b, 1'b0);
    endtask
    task go(input int b, c, input logic [31:0] a, input logic s, input int e);
        @(negedge clk);
        ad = a;
        s32 = s;
        req(b, 1'b1);
        if (c >= 0) req(c, 1'b1);
        wt(b, n);
        chk(n, e);
        if (c >= 0) wt(c, n);
    endtask
    task t_fixed;
        go(2, -1, 32'h0000_0100, 1'b0, 2);
        chk(data_rdata, 32'h0100_5A5A);
        go(2, -1, 32'h003F_E010, 1'b0, 3);
        go(2, -1, 32'h0033_FFF8, 1'b0, 18);
        go(3, -1, 32'h0038_0400, 1'b0, 3);
        chk(prog_rdata, 32'h0400_5A59);
        $display("fixed waits done");
    endtask
    task t_flash;
        {flash_page_wait, flash_rand_wait} = 8'h23;
        go(2, -1, 32'h0030_0000, 1'b0, 5);
        go(2, -1, 32'h0030_0004, 1'b0, 4);
        {flash_page_wait, flash_rand_wait} = 8'h00;
        go(2, -1, 32'h0030_0008, 1'b0, 3);
        $display("flash waits done");
    endtask
    task t_ext;
        external_zone_timing_regs = 15'h0004;
        go(2, -1, 32'h0001_0000, 1'b0, 6);
        {zr, rdy} = 4'h2;
        rdy <= #700 1'b1;
        go(2, -1, 32'h0001_0000, 1'b0, 9);
        external_zone_timing_regs = 15'h0000;
        go(0, -1, 32'h0001_0000, 1'b0, 3);
        {wbuf_en, wbuf_space} = 2'h3;
        go(0, -1, 32'h0001_0000, 1'b0, 1);
        wbuf_space = 1'b0;
        go(0, -1, 32'h0001_0000, 1'b0, 3);
        $display("external waits done");
    endtask
    task t_dma;
        go(5, -1, 32'h0000_0200, 1'b0, 5);
        chk(dma_rdata, 32'h0200_5A5A);
        go(6, -1, 32'h0000_5000, 1'b1, 5);
        go(5, -1, 32'h0000_6000, 1'b0, -1);
        go(0, -1, 32'h0000_7000, 1'b1, -1);
        go(0, -1, 32'h0000_6000, 1'b1, 2);
        chk({16'h0000, periph_addr}, 32'h0000_6000);
        chk(periph_wdata, 32'h0000_6000);
        $display("dma and frames done");
    endtask
    task t_arb;
        go(0, 1, 32'h0000_0100, 1'b0, 2);
        go(3, 4, 32'h0000_0100, 1'b0, 2);
        go(2, 5, 32'h0000_0100, 1'b0, 3);
        $display("arbitration done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_fixed();
        t_flash();
        t_ext();
        t_dma();
        t_arb();
        end_of_test();
    end
endmodule
`default_nettype wire
